/* File: wsw_watchdog_sleep.v */
// watchdog timer with sleep entry and wake-up control, axi4-lite registers
//
// Notes on behaviour
// - watchdog counts only ticks of the 31 kHz low-frequency oscillator.
// - mode 11 runs awake and asleep; mode 10 runs awake only.
// - mode 01 follows software enable; mode 00 never runs.
// - period select 00000 is 1:32, each step doubles, up to 10010.
// - period codes 10011 to 11111 behave as the 1:32 minimum.
// - period select resets to 01011, a 1:65536 prescale.
// - awake time-out without a clear requests a device reset.
// - asleep time-out wakes the core and records it in the flags.
// - count cleared on reset, clear, sleep, wake, oscillator fail, disable.
// - crystal clock wake holds watchdog cleared until start-up timer ends.
// - oscillator divider changes leave the count alone.
// - sleep clears power-down flag, sets time-out flag, stops cpu clock.
// - low-frequency, timer, sensing and converter oscillators keep running asleep.
// - io ports hold their state throughout sleep.
// - other reset sources stay active during sleep.
// - reset wakes by resetting; watchdog or interrupt wake resumes execution.
// - enabled interrupt wakes regardless of global enable.
// - after wake, vector to service routine only if global enable set.
// - enabled interrupt pending before sleep makes sleep a no-operation.
// - interrupt during sleep entry completes sleep then wakes at once.
//
// Added by the designer: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "wsw_defines.vh"

module wsw_watchdog_sleep #(
	parameter NIRQ = 8,
	parameter CW   = 23
) (
	input  wire            mclk,
	input  wire            rst_b,
	input  wire            clk_en,
	input  wire            low_freq_internal_osc,
	input  wire            sleep_instr,
	input  wire            watchdog_clear_instr,
	input  wire [NIRQ-1:0] irq_flags,
	input  wire [NIRQ-1:0] irq_enables,
	input  wire            global_irq_enable,
	input  wire            osc_fail,
	input  wire            crystal_clock_sel,
	input  wire            osc_startup_timer_busy,
	input  wire            internal_osc_divider_select_chg,
	input  wire [7:0]      s_axi_awaddr,
	input  wire            s_axi_awvalid,
	output wire            s_axi_awready,
	input  wire [31:0]     s_axi_wdata,
	input  wire [3:0]      s_axi_wstrb,
	input  wire            s_axi_wvalid,
	output wire            s_axi_wready,
	output wire [1:0]      s_axi_bresp,
	output wire            s_axi_bvalid,
	input  wire            s_axi_bready,
	input  wire [7:0]      s_axi_araddr,
	input  wire            s_axi_arvalid,
	output wire            s_axi_arready,
	output wire [31:0]     s_axi_rdata,
	output wire [1:0]      s_axi_rresp,
	output wire            s_axi_rvalid,
	input  wire            s_axi_rready,
	output wire            device_reset_req,
	output wire            cpu_clk_run,
	output wire            resume_pulse,
	output wire            isr_vector_pulse,
	output wire            sleep_nop_pulse,
	output wire            io_hold,
	output wire            sleep_osc_keep_on
);

// ------------------------------------------------------------
// state
// ------------------------------------------------------------
reg  [4:0]    psel_ff;
reg           sw_en_ff;
reg  [1:0]    mode_ff;
reg           to_n_ff;
reg           pd_n_ff;
reg           asleep_ff;
reg           cpu_run_ff;
reg           ost_hold_ff;
reg  [CW-1:0] cnt_ff;
reg           lf_meta_ff;
reg           lf_sync_ff;
reg           lf_prev_ff;
reg           rst_req_ff;
reg           resume_ff;
reg           vector_ff;
reg           nop_ff;
reg           wake_irq_ff;
reg           osc_keep_ff;
reg           awready_ff;
reg           wready_ff;
reg           aw_got_ff;
reg           w_got_ff;
reg  [7:0]    awaddr_ff;
reg  [31:0]   wdata_ff;
reg  [3:0]    wstrb_ff;
reg           bvalid_ff;
reg  [1:0]    bresp_ff;
reg           arready_ff;
reg           rvalid_ff;
reg  [31:0]   rdata_ff;
reg  [1:0]    rresp_ff;

reg  [CW-1:0] nxt_cnt;
reg           wdt_active;
reg  [4:0]    eff_psel;
reg  [CW-1:0] limit_m1;
reg  [31:0]   rd_word;
reg           rd_ok;

wire          lf_tick;
wire          irq_pending;
wire          sleep_go;
wire          sleep_nop;
wire          wdt_timeout;
wire          wake_irq;
wire          wake_any;
wire          wdt_clear;
wire          wr_fire;
wire          rd_fire;

// ------------------------------------------------------------
// low-frequency oscillator sampling
// ------------------------------------------------------------
// two-stage sync
always @(posedge mclk or negedge rst_b) begin
	if (!rst_b) begin
		lf_meta_ff <= 1'b0;
		lf_sync_ff <= 1'b0;
		lf_prev_ff <= 1'b0;
	end else if (clk_en) begin
		lf_meta_ff <= low_freq_internal_osc;
		lf_sync_ff <= lf_meta_ff;
		lf_prev_ff <= lf_sync_ff;
	end
end

assign lf_tick = lf_sync_ff & ~lf_prev_ff;

// ------------------------------------------------------------
// mode and period decode
// ------------------------------------------------------------
always @* begin
	case (mode_ff)
		`WSW_MODE_ALWAYS:     wdt_active = 1'b1;
		`WSW_MODE_AWAKE_ONLY: wdt_active = ~asleep_ff;
		`WSW_MODE_BY_SW:      wdt_active = sw_en_ff;
		default:              wdt_active = 1'b0;
	endcase
	if (psel_ff > `WSW_PSEL_MAX)
		eff_psel = `WSW_PSEL_MIN;
	else
		eff_psel = psel_ff;
	limit_m1 = {CW{1'b1}} >> (`WSW_PSEL_MAX - eff_psel);
end

// ------------------------------------------------------------
// sleep and wake decisions
// ------------------------------------------------------------
// individual enables only
assign irq_pending = |(irq_flags & irq_enables);
// pending interrupt turns sleep into a nop
assign sleep_nop   = sleep_instr & ~asleep_ff & irq_pending;
assign sleep_go    = sleep_instr & ~asleep_ff & ~irq_pending;
assign wdt_timeout = wdt_active & lf_tick & (cnt_ff == limit_m1) & ~ost_hold_ff;
assign wake_irq    = asleep_ff & irq_pending;
assign wake_any    = wake_irq | (asleep_ff & wdt_timeout);
assign wdt_clear   = ~wdt_active | watchdog_clear_instr | sleep_go | wake_any | osc_fail | ost_hold_ff;

// divider change does not appear in the count path
always @* begin
	if (wdt_clear)
		nxt_cnt = {CW{1'b0}};
	else if (lf_tick)
		nxt_cnt = cnt_ff + {{(CW-1){1'b0}}, 1'b1};
	else
		nxt_cnt = cnt_ff;
end

always @(posedge mclk or negedge rst_b) begin
	if (!rst_b) begin
		cnt_ff      <= {CW{1'b0}};
		asleep_ff   <= 1'b0;
		cpu_run_ff  <= 1'b1;
		ost_hold_ff <= 1'b0;
		to_n_ff     <= 1'b1;
		pd_n_ff     <= 1'b1;
		rst_req_ff  <= 1'b0;
		resume_ff   <= 1'b0;
		vector_ff   <= 1'b0;
		nop_ff      <= 1'b0;
		wake_irq_ff <= 1'b0;
		osc_keep_ff <= 1'b0;
	end else if (clk_en) begin
		cnt_ff      <= nxt_cnt;
		osc_keep_ff <= 1'b1;
		rst_req_ff  <= wdt_timeout & ~asleep_ff;
		resume_ff   <= wake_any;
		wake_irq_ff <= wake_irq;
		vector_ff   <= wake_irq & global_irq_enable;
		nop_ff      <= sleep_nop;
		if (wake_any & crystal_clock_sel)
			ost_hold_ff <= 1'b1;
		else if (!osc_startup_timer_busy)
			ost_hold_ff <= 1'b0;
		if (sleep_go) begin
			asleep_ff <= 1'b1;
			cpu_run_ff <= 1'b0;
			pd_n_ff   <= 1'b0;
			to_n_ff   <= 1'b1;
		end else if (wake_any) begin
			asleep_ff <= 1'b0;
			cpu_run_ff <= 1'b1;
			if (!wake_irq)
				to_n_ff <= 1'b0;
		end else if (watchdog_clear_instr) begin
			to_n_ff <= 1'b1;
			pd_n_ff <= 1'b1;
		end
	end
end

// ------------------------------------------------------------
// axi4-lite write channel
// ------------------------------------------------------------
// address and data may come in either order; the write happens once both are held
assign wr_fire = aw_got_ff & w_got_ff & ~bvalid_ff;

always @(posedge mclk or negedge rst_b) begin
	if (!rst_b) begin
		awready_ff <= 1'b0;
		wready_ff  <= 1'b0;
		aw_got_ff  <= 1'b0;
		w_got_ff   <= 1'b0;
		awaddr_ff  <= 8'h00;
		wdata_ff   <= 32'h0000_0000;
		wstrb_ff   <= 4'h0;
		bvalid_ff  <= 1'b0;
		bresp_ff   <= `WSW_RESP_OKAY;
		psel_ff    <= `WSW_PSEL_RST;
		sw_en_ff   <= `WSW_SW_EN_RST;
		mode_ff    <= `WSW_MODE_RST;
	end else if (clk_en) begin
		awready_ff <= ~aw_got_ff & ~(s_axi_awvalid & awready_ff) & ~bvalid_ff;
		wready_ff  <= ~w_got_ff & ~(s_axi_wvalid & wready_ff) & ~bvalid_ff;
		if (s_axi_awvalid & awready_ff) begin
			aw_got_ff <= 1'b1;
			awaddr_ff <= s_axi_awaddr;
		end
		if (s_axi_wvalid & wready_ff) begin
			w_got_ff <= 1'b1;
			wdata_ff <= s_axi_wdata;
			wstrb_ff <= s_axi_wstrb;
		end
		if (wr_fire) begin
			aw_got_ff <= 1'b0;
			w_got_ff  <= 1'b0;
			bvalid_ff <= 1'b1;
			bresp_ff  <= `WSW_RESP_OKAY;
			case (awaddr_ff)
				`WSW_OFS_WDT_CTRL: begin
					if (wstrb_ff[0]) begin
						psel_ff  <= wdata_ff[`WSW_PSEL_MSB:`WSW_PSEL_LSB];
						sw_en_ff <= wdata_ff[`WSW_SW_EN_BIT];
					end
				end
				`WSW_OFS_MODE_CFG: begin
					if (wstrb_ff[0])
						mode_ff <= wdata_ff[1:0];
				end
				// flags and sleep state are read only; writes are accepted and dropped
				`WSW_OFS_CORE_FLAGS, `WSW_OFS_SLEEP_STATE: bresp_ff <= `WSW_RESP_OKAY;
				default: bresp_ff <= `WSW_RESP_SLVERR;
			endcase
		end else if (bvalid_ff & s_axi_bready) begin
			bvalid_ff <= 1'b0;
		end
	end
end

// ------------------------------------------------------------
// axi4-lite read channel
// ------------------------------------------------------------
assign rd_fire = s_axi_arvalid & arready_ff;

always @* begin
	rd_word = 32'h0000_0000;
	rd_ok   = 1'b1;
	case (s_axi_araddr)
		`WSW_OFS_WDT_CTRL: begin
			rd_word[`WSW_PSEL_MSB:`WSW_PSEL_LSB] = psel_ff;
			rd_word[`WSW_SW_EN_BIT]              = sw_en_ff;
		end
		`WSW_OFS_CORE_FLAGS: begin
			rd_word[`WSW_TO_BIT] = to_n_ff;
			rd_word[`WSW_PD_BIT] = pd_n_ff;
		end
		`WSW_OFS_MODE_CFG: rd_word[1:0] = mode_ff;
		`WSW_OFS_SLEEP_STATE: begin
			rd_word[0] = asleep_ff;
			rd_word[1] = wdt_active;
			rd_word[2] = ost_hold_ff;
			rd_word[3] = wake_irq_ff;
		end
		default: rd_ok = 1'b0;
	endcase
end

always @(posedge mclk or negedge rst_b) begin
	if (!rst_b) begin
		arready_ff <= 1'b0;
		rvalid_ff  <= 1'b0;
		rdata_ff   <= 32'h0000_0000;
		rresp_ff   <= `WSW_RESP_OKAY;
	end else if (clk_en) begin
		arready_ff <= ~rvalid_ff & ~rd_fire;
		if (rd_fire) begin
			rvalid_ff <= 1'b1;
			rdata_ff  <= rd_word;
			rresp_ff  <= rd_ok ? `WSW_RESP_OKAY : `WSW_RESP_SLVERR;
		end else if (rvalid_ff & s_axi_rready) begin
			rvalid_ff <= 1'b0;
		end
	end
end

// ------------------------------------------------------------
// outputs
// ------------------------------------------------------------
assign s_axi_awready     = awready_ff;
assign s_axi_wready      = wready_ff;
assign s_axi_bvalid      = bvalid_ff;
assign s_axi_bresp       = bresp_ff;
assign s_axi_arready     = arready_ff;
assign s_axi_rvalid      = rvalid_ff;
assign s_axi_rdata       = rdata_ff;
assign s_axi_rresp       = rresp_ff;
assign device_reset_req  = rst_req_ff;
assign cpu_clk_run       = cpu_run_ff;
assign io_hold           = asleep_ff;
assign resume_pulse      = resume_ff;
assign isr_vector_pulse  = vector_ff;
assign sleep_nop_pulse   = nop_ff;
assign sleep_osc_keep_on = osc_keep_ff;

endmodule // wsw_watchdog_sleep

/* File: wsw_defines.vh */
// constants for the watchdog, sleep and wake-up control block
`ifndef WSW_DEFINES_VH
`define WSW_DEFINES_VH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define WSW_OFS_WDT_CTRL     8'h00
`define WSW_OFS_CORE_FLAGS   8'h04
`define WSW_OFS_MODE_CFG     8'h08
`define WSW_OFS_SLEEP_STATE  8'h0c

// ------------------------------------------------------------
// field positions and reset values
// ------------------------------------------------------------
`define WSW_SW_EN_BIT        0
`define WSW_PSEL_LSB         1
`define WSW_PSEL_MSB         5
`define WSW_TO_BIT           4
`define WSW_PD_BIT           3
`define WSW_PSEL_RST         5'h0b
`define WSW_SW_EN_RST        1'h0
`define WSW_MODE_RST         2'h3

// ------------------------------------------------------------
// watchdog modes and prescale range
// ------------------------------------------------------------
`define WSW_MODE_OFF         2'h0
`define WSW_MODE_BY_SW       2'h1
`define WSW_MODE_AWAKE_ONLY  2'h2
`define WSW_MODE_ALWAYS      2'h3
`define WSW_PSEL_MAX         5'h12
`define WSW_PSEL_MIN         5'h00
`define WSW_PRESCALE_LOG2    5'h05

// ------------------------------------------------------------
// bus answers
// ------------------------------------------------------------
`define WSW_RESP_OKAY        2'h0
`define WSW_RESP_SLVERR      2'h2

`endif

/* File: wsw_ws_asserts.sv */
// concurrent checks for the watchdog sleep and wake block
`timescale 1ns/1ps
module wsw_ws_asserts #(
	parameter NIRQ = 8
) (
	input wire		mclk,
	input wire		rst_b,
	input wire		clk_en,
	input wire		sleep_instr,
	input wire [NIRQ-1:0]	irq_flags,
	input wire [NIRQ-1:0]	irq_enables,
	input wire		cpu_clk_run,
	input wire		io_hold,
	input wire		resume_pulse,
	input wire		isr_vector_pulse,
	input wire		sleep_nop_pulse,
	input wire		device_reset_req,
	input wire		sleep_osc_keep_on
);
	wire pend = |(irq_flags & irq_enables);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);
	// ----------------------------------------
	// sleep entry and wake-up
	// ----------------------------------------
	chk_sleep_entry: assert property (clk_en && sleep_instr && cpu_clk_run && !pend |=> !cpu_clk_run)
		else $error("sleep entry did not stop the cpu clock");
	chk_nop_sleep: assert property (clk_en && sleep_instr && cpu_clk_run && pend |=> sleep_nop_pulse && cpu_clk_run)
		else $error("pending interrupt did not turn sleep into a nop");
	chk_irq_wake: assert property (clk_en && !cpu_clk_run && pend |=> cpu_clk_run && resume_pulse)
		else $error("enabled interrupt did not wake the core");
	chk_isr_on_wake: assert property (isr_vector_pulse |-> resume_pulse)
		else $error("vector pulse without a wake");
	chk_resume_src: assert property (resume_pulse |-> $rose(cpu_clk_run))
		else $error("resume pulse while not leaving sleep");
	// io hold mirrors sleep, so a user sees ports frozen exactly while asleep
	chk_io_frozen: assert property (io_hold == !cpu_clk_run)
		else $error("io hold does not follow sleep state");
	chk_osc_asleep: assert property (!cpu_clk_run |-> sleep_osc_keep_on)
		else $error("oscillators not kept on while asleep");
	chk_no_sleep_rst: assert property (device_reset_req |-> $past(cpu_clk_run))
		else $error("watchdog reset issued while asleep");
	cov_wdt_reset: cover property (device_reset_req);
	cov_isr_wake: cover property (resume_pulse && isr_vector_pulse);
	cov_nop: cover property (sleep_nop_pulse);
endmodule // wsw_ws_asserts

bind wsw_watchdog_sleep wsw_ws_asserts #(.NIRQ(NIRQ)) u_chk (.mclk, .rst_b, .clk_en, .sleep_instr, .irq_flags,
	.irq_enables, .cpu_clk_run, .io_hold, .resume_pulse, .isr_vector_pulse, .sleep_nop_pulse,
	.device_reset_req, .sleep_osc_keep_on);

/* File: wsw_core_model.sv */
// processor core model issuing sleep and watchdog clear instructions
`timescale 1ns/1ps
module wsw_core_model (
	input wire	mclk,
	input wire	cpu_clk_run,
	output logic	sleep_instr,
	output logic	watchdog_clear_instr,
	output logic	stalled
);
	initial begin
		sleep_instr = 1'b0;
		watchdog_clear_instr = 1'b0;
		stalled = 1'b0;
	end
	// a stopped core executes nothing, so wait for its clock
	// run state is looked at mid-cycle, where the registered level has settled
	task automatic exec(input bit slp);
		int n;
		bit ok;
		n = 0;
		@(negedge mclk);
		while (!cpu_clk_run && n < 1000) begin
			@(negedge mclk);
			n++;
		end
		ok = cpu_clk_run;
		@(posedge mclk);
		if (!ok) begin
			stalled <= 1'b1;
		end
		if (slp) begin
			sleep_instr <= 1'b1;
		end else begin
			watchdog_clear_instr <= 1'b1;
		end
		@(posedge mclk);
		sleep_instr <= 1'b0;
		watchdog_clear_instr <= 1'b0;
	endtask
endmodule // wsw_core_model

/* File: tb_watchdog_sleep_wake_control.sv */
// self-checking bench for the watchdog sleep and wake block
`timescale 1ns/1ps
module tb_watchdog_sleep_wake_control;
	logic		mclk, rst_b, low_freq_internal_osc, global_irq_enable, isr_seen;
	logic		clk_en, osc_fail, crystal_clock_sel, osc_startup_timer_busy, internal_osc_divider_select_chg;
	logic		s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic [7:0]	irq_flags, irq_enables, s_axi_awaddr, s_axi_araddr;
	logic [31:0]	s_axi_wdata, q;
	logic [3:0]	s_axi_wstrb;
	logic [1:0]	osc_cnt, r;
	wire		s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0]	s_axi_bresp, s_axi_rresp;
	wire [31:0]	s_axi_rdata;
	wire		sleep_instr, watchdog_clear_instr, device_reset_req, cpu_clk_run;
	wire		resume_pulse, isr_vector_pulse, sleep_nop_pulse;
	wire		io_hold, sleep_osc_keep_on, core_stalled;
	int		error_cnt, tests_run, cyc;

	wsw_watchdog_sleep uut (.mclk, .rst_b, .clk_en, .low_freq_internal_osc, .sleep_instr,
		.watchdog_clear_instr, .irq_flags, .irq_enables, .global_irq_enable, .osc_fail,
		.crystal_clock_sel, .osc_startup_timer_busy, .internal_osc_divider_select_chg,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .device_reset_req,
		.cpu_clk_run, .resume_pulse, .isr_vector_pulse, .sleep_nop_pulse, .io_hold, .sleep_osc_keep_on);
	wsw_core_model u_core (.mclk, .cpu_clk_run, .sleep_instr, .watchdog_clear_instr, .stalled(core_stalled));

	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	// slow oscillator: each level lasts 4 mclk, so one tick per 8 mclk
	always @(posedge mclk) begin
		osc_cnt <= osc_cnt + 2'h1;
		if (osc_cnt == 2'h3) begin
			low_freq_internal_osc <= ~low_freq_internal_osc;
		end
	end
	// a core that never wakes ends the run as a mismatch
	always @(posedge mclk) begin
		if (core_stalled) begin
			error_cnt++;
			end_sim();
		end
	end
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic end_sim();
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
			error_cnt++;
		end
	endtask
	// handshakes are read mid-cycle so they reflect the coming edge
	task automatic bus(input bit wr, input logic [7:0] a, input logic [31:0] d);
		bit aw, w, ar, done;
		int n;
		done = 1'b0;
		n = 0;
		if (wr) begin
			s_axi_awaddr <= a;
			s_axi_wdata <= d;
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid <= 1'b1;
			s_axi_bready <= 1'b1;
		end else begin
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'b1;
			s_axi_rready <= 1'b1;
		end
		while (!done) begin
			@(negedge mclk);
			aw = s_axi_awvalid && s_axi_awready;
			w = s_axi_wvalid && s_axi_wready;
			ar = s_axi_arvalid && s_axi_arready;
			done = wr ? s_axi_bvalid : s_axi_rvalid;
			q = s_axi_rdata;
			r = wr ? s_axi_bresp : s_axi_rresp;
			@(posedge mclk);
			if (aw) s_axi_awvalid <= 1'b0;
			if (w) s_axi_wvalid <= 1'b0;
			if (ar) s_axi_arvalid <= 1'b0;
			if (done) begin
				s_axi_bready <= 1'b0;
				s_axi_rready <= 1'b0;
			end
			if (++n > 100) begin
				error_cnt++;
				end_sim();
			end
		end
		@(posedge mclk);
	endtask
	task automatic wait_pulse(input bit sel, input int lim);
		cyc = 0;
		isr_seen = 1'b0;
		while (cyc < lim) begin
			@(negedge mclk);
			if (sel ? resume_pulse : device_reset_req) begin
				isr_seen = isr_vector_pulse;
				break;
			end
			cyc++;
		end
		@(posedge mclk);
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset();
		bus(0, 8'h00, 32'h0);
		chk("ctrl_rst", q, 32'h16);
		bus(0, 8'h04, 32'h0);
		chk("flags_rst", q, 32'h18);
		bus(0, 8'h08, 32'h0);
		chk("mode_rst", q, 32'h3);
		bus(0, 8'h10, 32'h0);
		chk("unmapped", {q[29:0], r}, 32'h2);
	endtask
	task automatic t_period();
		logic [4:0] code [4] = '{5'h00, 5'h01, 5'h13, 5'h1f};
		int tk [4] = '{32, 64, 32, 32};
		for (int i = 0; i < 4; i++) begin
			bus(1, 8'h00, {26'h0, code[i], 1'b0});
			u_core.exec(0);
			wait_pulse(0, 700);
			chk("period", cyc >= (tk[i] - 2) * 8 && cyc <= tk[i] * 8 + 16, 32'h1);
		end
	endtask
	task automatic t_modes();
		logic [1:0] md [5] = '{2'h3, 2'h2, 2'h1, 2'h1, 2'h0};
		logic [4:0] en = 5'h14;
		logic [4:0] run = 5'h07;
		for (int i = 0; i < 5; i++) begin
			bus(1, 8'h08, {30'h0, md[i]});
			bus(1, 8'h00, {31'h0, en[i]});
			u_core.exec(0);
			wait_pulse(0, 400);
			chk("mode_run", cyc < 400, run[i]);
		end
	endtask
	task automatic t_sleep();
		bus(1, 8'h08, 32'h3);
		bus(1, 8'h00, 32'h0);
		irq_enables <= 8'h01;
		u_core.exec(1);
		wait_pulse(1, 400);
		chk("wdt_wake", cyc < 400, 32'h1);
		bus(0, 8'h04, 32'h0);
		chk("flags_wdt", q, 32'h00);
		bus(1, 8'h08, 32'h2);
		u_core.exec(1);
		wait_pulse(1, 400);
		chk("off_asleep", cyc < 400, 32'h0);
		for (int g = 0; g < 2; g++) begin
			if (g) begin
				u_core.exec(1);
			end
			global_irq_enable <= g[0];
			irq_flags <= 8'h01;
			wait_pulse(1, 8);
			chk("irq_wake", cyc < 8, 32'h1);
			chk("isr", isr_seen, g);
			bus(0, 8'h04, 32'h0);
			chk("flags_irq", q, 32'h10);
			irq_flags <= 8'h00;
		end
		u_core.exec(0);
		irq_flags <= 8'h01;
		u_core.exec(1);
		bus(0, 8'h04, 32'h0);
		chk("flags_nop", q, 32'h18);
		chk("awake_nop", cpu_clk_run, 32'h1);
		irq_flags <= 8'h00;
	endtask
	// side inputs: strobes, clock enable, oscillator fail, crystal wake, reset in sleep
	task automatic t_side();
		s_axi_wstrb <= 4'h0;
		bus(1, 8'h00, 32'h3f);
		s_axi_wstrb <= 4'hf;
		bus(0, 8'h00, 32'h0);
		chk("wstrb_off", q, 32'h0);
		bus(1, 8'h10, 32'h0);
		chk("wr_unmapped", r, 32'h2);
		bus(1, 8'h08, 32'h3);
		osc_fail <= 1'b1;
		u_core.exec(0);
		wait_pulse(0, 300);
		chk("fail_hold", cyc, 32'd300);
		osc_fail <= 1'b0;
		internal_osc_divider_select_chg <= 1'b1;
		wait_pulse(0, 700);
		chk("fail_release", cyc >= 240 && cyc <= 272, 32'h1);
		internal_osc_divider_select_chg <= 1'b0;
		u_core.exec(0);
		clk_en <= 1'b0;
		wait_pulse(0, 300);
		chk("frozen", cyc, 32'd300);
		clk_en <= 1'b1;
		wait_pulse(0, 700);
		chk("thawed", cyc >= 8 && cyc <= 272, 32'h1);
		crystal_clock_sel <= 1'b1;
		osc_startup_timer_busy <= 1'b1;
		u_core.exec(1);
		bus(0, 8'h0c, 32'h0);
		chk("sleep_state", q, 32'h3);
		@(negedge mclk);
		chk("io_hold", io_hold, 32'h1);
		chk("osc_keep", sleep_osc_keep_on, 32'h1);
		@(posedge mclk);
		irq_flags <= 8'h01;
		wait_pulse(1, 8);
		chk("xtal_wake", cyc < 8, 32'h1);
		irq_flags <= 8'h00;
		wait_pulse(0, 300);
		chk("ost_hold", cyc, 32'd300);
		chk("io_free", io_hold, 32'h0);
		{osc_startup_timer_busy, crystal_clock_sel} <= 2'h0;
		wait_pulse(0, 700);
		chk("ost_done", cyc >= 240 && cyc <= 272, 32'h1);
		u_core.exec(1);
		repeat (4) @(posedge mclk);
		chk("slept", cpu_clk_run, 32'h0);
		rst_b <= 1'b0;
		repeat (2) @(posedge mclk);
		chk("rst_wake", cpu_clk_run, 32'h1);
		rst_b <= 1'b1;
		repeat (2) @(posedge mclk);
		bus(0, 8'h04, 32'h0);
		chk("flags_rst2", q, 32'h18);
		bus(0, 8'h00, 32'h0);
		chk("ctrl_rst2", q, 32'h16);
	endtask

	initial begin
		rst_b = 1'b0;
		osc_cnt = 2'h0;
		low_freq_internal_osc = 1'b0;
		global_irq_enable = 1'b0;
		irq_flags = 8'h00;
		irq_enables = 8'h00;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hf;
		clk_en = 1'b1;
		{osc_fail, crystal_clock_sel, osc_startup_timer_busy, internal_osc_divider_select_chg} = 4'h0;
		repeat (16) @(posedge mclk);
		rst_b <= 1'b1;
		repeat (2) @(posedge mclk);
		t_reset();
		t_period();
		t_modes();
		t_sleep();
		t_side();
		end_sim();
	end
endmodule // tb_watchdog_sleep_wake_control
